// ==== timer16_pkg.sv ====
// Purpose: constants and types for the 16-bit timer output compare block
// Assumes: APB register words, data in the low byte
// Notes:   offsets are byte addresses, one word per register
`default_nettype none
package timer16_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] ADDR_CONTROL  = 8'h00;
   localparam logic [7:0] ADDR_ACTION   = 8'h04;
   localparam logic [7:0] ADDR_FORCE    = 8'h08;
   localparam logic [7:0] ADDR_IRQ_EN   = 8'h0c;
   localparam logic [7:0] ADDR_FLAGS    = 8'h10;
   localparam logic [7:0] ADDR_CNT_LOW  = 8'h14;
   localparam logic [7:0] ADDR_CNT_HIGH = 8'h18;
   localparam logic [7:0] ADDR_PINS     = 8'h1c;
   localparam logic [7:0] ADDR_MATCH_A  = 8'h20;
   localparam logic [7:0] ADDR_LAST     = 8'h34;
   localparam int         NUM_CH        = 3;
   // ==========================================================
   // field values
   localparam logic [2:0] CS_STOP    = 3'h0;
   localparam logic [2:0] CS_SYSCLK  = 3'h1;
   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR  = 2'h2;
   localparam logic [1:0] ACT_SET    = 2'h3;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] TOP_8BIT  = 16'h00ff;
   localparam logic [15:0] TOP_9BIT  = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      TOP_MAX, TOP_FIXED, TOP_MATCH_A, TOP_CAPTURE
   } top_src_t;
   typedef struct packed {
      logic        pwm;
      logic        dual;
      logic        clr;
      logic        db_bottom;
      top_src_t    src;
      logic [15:0] fixed;
   } mode_t;
   typedef struct packed {
      logic [15:0]       count_value;
      logic              up;
      logic              block;
      logic [7:0]        temp;
      logic [2:0][15:0]  match_buf;
      logic [2:0][15:0]  match_value;
      logic [2:0]        waveform_out_bit;
      logic [2:0]        match_flag;
      logic              overflow_flag;
      logic [3:0]        waveform_select;
      logic [2:0]        clock_source_select;
      logic [2:0][1:0]   output_action_select;
      logic [3:0]        irq_enable;
      logic [2:0]        pin_direction_bit;
      logic [2:0]        port_value;
      logic [31:0]       rdata;
   } state_t;
   localparam state_t STATE_RESET = '0;
endpackage
`default_nettype wire

// ==== timer16_oc.sv ====
// Purpose: 16-bit counter with three output compare channels on APB
// Assumes: timer_tick is a one-cycle prescaler enable from outside
// Notes:   pready is always high, transfers finish in the access cycle
//
// Implementation choices: the register offsets and the APB slave port.
`default_nettype none
module timer16_oc
   import timer16_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        timer_tick,
   input  wire logic [15:0] capture_value,
   input  wire logic [3:0]  irq_ack,
   output logic             overflow_irq,
   output logic [2:0]       match_irq,
   output logic [2:0]       waveform_out_bit,
   output logic [2:0]       pin_out,
   output logic [2:0]       pin_oe
);

   // ==========================================================
   // helpers
   function automatic mode_t decode_mode(input logic [3:0] m);
      mode_t d;
      d = '0;
      d.src = TOP_MAX;
      unique case (m[1:0])
         2'h1:    d.fixed = TOP_8BIT;
         2'h2:    d.fixed = TOP_9BIT;
         default: d.fixed = TOP_10BIT;
      endcase
      unique case (m)
         4'h1, 4'h2, 4'h3: begin
            d.pwm = 1'b1;
            d.dual = 1'b1;
            d.src = TOP_FIXED;
         end
         4'h4: begin
            d.clr = 1'b1;
            d.src = TOP_MATCH_A;
         end
         4'hc: begin
            d.clr = 1'b1;
            d.src = TOP_CAPTURE;
         end
         4'h5, 4'h6, 4'h7: begin
            d.pwm = 1'b1;
            d.clr = 1'b1;
            d.src = TOP_FIXED;
         end
         4'he, 4'hf: begin
            d.pwm = 1'b1;
            d.clr = 1'b1;
            d.src = m[0] ? TOP_MATCH_A : TOP_CAPTURE;
         end
         4'h8, 4'h9, 4'ha, 4'hb: begin
            d.pwm = 1'b1;
            d.dual = 1'b1;
            d.db_bottom = ~m[1];
            d.src = m[0] ? TOP_MATCH_A : TOP_CAPTURE;
         end
         default: d.src = TOP_MAX; // normal, reserved code treated so
      endcase
      return d;
   endfunction

   function automatic logic on_match(input mode_t d, input logic [1:0] a,
                                     input logic o, input logic up);
      logic r;
      r = o;
      if (a == ACT_NONE) begin
         r = o;
      end else if (!d.pwm) begin
         unique case (a)
            ACT_TOGGLE: r = ~o;
            ACT_CLEAR:  r = 1'b0;
            default:    r = 1'b1;
         endcase
      end else if (a != ACT_TOGGLE) begin
         // pwm polarity only; counting is never touched here
         if (d.dual) begin
            r = (a == ACT_CLEAR) ? ~up : up;
         end else begin
            r = (a == ACT_CLEAR);
         end
      end
      return r;
   endfunction

   // ==========================================================
   // state
   state_t      st;
   state_t      nx;
   mode_t       md;
   logic [15:0] top;
   logic        at_top;
   logic        at_bot;
   logic        tick;
   logic        upd;
   logic        wr;
   logic        rd_setup;
   logic        cnt_wr;
   logic        is_match;
   logic [1:0]  ch;
   logic [2:0]  hit;
   logic [2:0]  flag_clr;

   assign md = decode_mode(st.waveform_select);
   // capture value only feeds top; action bits never reach it
   always_comb begin
      unique case (md.src)
         TOP_MAX:     top = COUNT_MAX;
         TOP_FIXED:   top = md.fixed;
         TOP_MATCH_A: top = st.match_value[0];
         default:     top = capture_value;
      endcase
   end
   assign at_top = (st.count_value == top);
   assign at_bot = (st.count_value == 16'h0000);
   assign tick   = (st.clock_source_select == CS_SYSCLK) ||
                   (st.clock_source_select != CS_STOP && timer_tick);
   assign upd    = md.pwm && (md.db_bottom ? (at_bot && !st.up)
                            : (md.dual ? (at_top && st.up) : at_top));
   assign wr       = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign cnt_wr   = wr && (paddr == ADDR_CNT_LOW);
   assign is_match = (paddr >= ADDR_MATCH_A) && (paddr <= ADDR_LAST) &&
                     (paddr[1:0] == 2'h0);
   assign ch       = 2'(paddr[4:3] - ADDR_MATCH_A[4:3]);
   assign flag_clr = ((wr && paddr == ADDR_FLAGS) ? pwdata[3:1] : 3'h0) |
                     irq_ack[3:1];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         // block flag hides matches for one tick after a counter write
         assign hit[gi] = (st.count_value == st.match_value[gi]) &&
                          !st.block;
         assign pin_out[gi] = (st.output_action_select[gi] != ACT_NONE) ?
                              st.waveform_out_bit[gi] :
                              st.port_value[gi];
         assign pin_oe[gi]  = st.pin_direction_bit[gi];
         assign match_irq[gi] = st.match_flag[gi] &&
                                st.irq_enable[gi+1];
      end
   endgenerate

   // ==========================================================
   // next state
   always_comb begin
      nx = st;
      // clears first so that a hardware set below wins
      nx.match_flag = st.match_flag & ~flag_clr;
      if (irq_ack[0] || (wr && paddr == ADDR_FLAGS && pwdata[0])) begin
         nx.overflow_flag = 1'b0;
      end
      if (tick) begin
         nx.block = 1'b0;
         for (int i = 0; i < NUM_CH; i++) begin
            if (hit[i]) begin
               nx.match_flag[i] = 1'b1;
               nx.waveform_out_bit[i] = on_match(md,
                  st.output_action_select[i], st.waveform_out_bit[i],
                  st.up);
            end
         end
         if (md.dual) begin
            if (st.up) begin
               nx.up = !at_top;
               nx.count_value = at_top ? 16'(st.count_value - 16'h1) :
                                         16'(st.count_value + 16'h1);
            end else begin
               nx.up = at_bot;
               nx.count_value = at_bot ? 16'(st.count_value + 16'h1) :
                                         16'(st.count_value - 16'h1);
            end
            if (at_bot && !st.up) begin
               nx.overflow_flag = 1'b1;
            end
         end else if (md.clr && at_top) begin
            nx.count_value = 16'h0000;
            if (md.pwm) begin
               nx.overflow_flag = 1'b1;
               for (int i = 0; i < NUM_CH; i++) begin
                  if (st.output_action_select[i][1]) begin
                     nx.waveform_out_bit[i] =
                        (st.output_action_select[i] == ACT_SET);
                  end
               end
            end
         end else begin
            nx.count_value = 16'(st.count_value + 16'h1);
            if (st.count_value == COUNT_MAX) begin
               nx.overflow_flag = 1'b1;
            end
         end
         if (upd) begin
            nx.match_value = st.match_buf;
         end
      end
      if (wr && paddr == ADDR_FORCE && !md.pwm) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (pwdata[i]) begin
               nx.waveform_out_bit[i] = on_match(md,
                  st.output_action_select[i], nx.waveform_out_bit[i],
                  st.up);
            end
         end
      end
      if (wr) begin
         unique case (paddr)
            ADDR_CONTROL: begin
               // output bits deliberately left alone on a mode change
               nx.waveform_select     = pwdata[3:0];
               nx.clock_source_select = pwdata[6:4];
            end
            ADDR_ACTION:   nx.output_action_select = pwdata[5:0];
            ADDR_IRQ_EN:   nx.irq_enable = pwdata[3:0];
            ADDR_CNT_HIGH: nx.temp = pwdata[7:0];
            ADDR_PINS: begin
               nx.pin_direction_bit = pwdata[2:0];
               nx.port_value        = pwdata[5:3];
            end
            ADDR_CNT_LOW: begin
               // overrides any count or clear made above
               nx.count_value = {st.temp, pwdata[7:0]};
               nx.block       = 1'b1;
            end
            default: begin
               if (is_match && paddr[2] == ADDR_MATCH_A[2]) begin
                  nx.match_buf[ch] = {st.temp, pwdata[7:0]};
                  if (!md.pwm) begin
                     nx.match_value[ch] = {st.temp, pwdata[7:0]};
                  end
               end else if (is_match) begin
                  nx.temp = pwdata[7:0];
               end
            end
         endcase
      end
      if (rd_setup) begin
         nx.rdata = 32'h0000_0000;
         unique case (paddr)
            ADDR_CONTROL: nx.rdata = {25'h0, st.clock_source_select,
                                      st.waveform_select};
            ADDR_ACTION:  nx.rdata = {26'h0, st.output_action_select};
            ADDR_IRQ_EN:  nx.rdata = {28'h0, st.irq_enable};
            ADDR_FLAGS:   nx.rdata = {28'h0, st.match_flag,
                                      st.overflow_flag};
            ADDR_CNT_LOW: begin
               nx.rdata = {24'h0, st.count_value[7:0]};
               nx.temp  = st.count_value[15:8];
            end
            ADDR_CNT_HIGH: nx.rdata = {24'h0, st.temp};
            ADDR_PINS:     nx.rdata = {26'h0, st.port_value,
                                       st.pin_direction_bit};
            default: begin
               if (is_match) begin
                  // high byte bypasses the latch: only the CPU changes it
                  nx.rdata = {24'h0, paddr[2] == ADDR_MATCH_A[2] ?
                              st.match_buf[ch][7:0] :
                              st.match_buf[ch][15:8]};
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= STATE_RESET;
      end else begin
         st <= nx;
      end
   end

   assign prdata           = st.rdata;
   assign pready           = 1'b1;
   assign pslverr          = psel && penable &&
                             (paddr > ADDR_LAST || paddr[1:0] != 2'h0);
   assign overflow_irq     = st.overflow_flag && st.irq_enable[0];
   assign waveform_out_bit = st.waveform_out_bit;

   // ==========================================================
   // checks
   // helper: a counter write still waiting for its first timer tick
   logic wr_wait_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_wait_r <= 1'b0;
      end else if (cnt_wr) begin
         wr_wait_r <= 1'b1;
      end else if (tick) begin
         wr_wait_r <= 1'b0;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_match_flag_set: assert property (tick && hit[0]
      |=> st.match_flag[0])
      else $error("match did not set flag");
   chk_set_beats_clear: assert property (tick && hit[1] &&
      flag_clr[1] |=> st.match_flag[1])
      else $error("clear won over match set");
   chk_force_no_flag: assert property (wr && paddr == ADDR_FORCE &&
      !(tick && hit[0]) && !st.match_flag[0] |=> !st.match_flag[0])
      else $error("force set the flag");
   chk_write_blocks: assert property (tick && wr_wait_r &&
      !st.match_flag[0] |=> !st.match_flag[0])
      else $error("match not blocked after counter write");
   chk_normal_wrap: assert property (st.waveform_select == 4'h0 &&
      tick && !cnt_wr && st.count_value == COUNT_MAX
      |=> st.count_value == 16'h0000 && st.overflow_flag)
      else $error("normal wrap or overflow wrong");
   chk_stopped: assert property (
      st.clock_source_select == CS_STOP && !cnt_wr
      |=> $stable(st.count_value))
      else $error("counter moved while stopped");
   chk_cpu_priority: assert property (cnt_wr
      |=> st.count_value == {$past(st.temp), $past(pwdata[7:0])})
      else $error("counter write lost");
   chk_ack_clear: assert property (irq_ack[1] &&
      !(tick && hit[0]) |=> !st.match_flag[0])
      else $error("service did not clear flag");
   chk_pin_override: assert property (
      st.output_action_select[2] == ACT_NONE
      |-> pin_out[2] == st.port_value[2])
      else $error("port value not passed");
   chk_action_hold: assert property (tick && hit[0] &&
      st.output_action_select[0] == ACT_NONE && !md.pwm && !wr
      |=> $stable(st.waveform_out_bit[0]))
      else $error("output changed with no action");
   chk_direct_write: assert property (
      wr && paddr == ADDR_MATCH_A && !md.pwm
      |=> st.match_value[0] == st.match_buf[0])
      else $error("unbuffered write missed working value");

   cov_overflow: cover property (tick && st.count_value == COUNT_MAX);
   cov_match: cover property (tick && hit[0] ##1 match_irq[0]);
   cov_force: cover property (wr && paddr == ADDR_FORCE && !md.pwm);
   cov_buffer_load: cover property (tick && upd);

endmodule
`default_nettype wire

// ==== testbench.sv ====
// Purpose: self-checking bench for the 16-bit timer output compare block
// Assumes: zero-wait APB slave, timer ticks driven here as one-cycle pulses
// Notes:   the counter is stopped between ticks so every count is exact, except t_run, which runs on the system clock and checks a bound
`default_nettype none
module testbench;
   import timer16_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // signals
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        timer_tick;
   logic [15:0] capture_value;
   logic [3:0]  irq_ack;
   logic        overflow_irq;
   logic [2:0]  match_irq;
   logic [2:0]  waveform_out_bit;
   logic [2:0]  pin_out;
   logic [2:0]  pin_oe;
   int          n_errors;
   int          num_checks;
   int          cycles;
   timer16_oc dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
      .capture_value(capture_value), .irq_ack(irq_ack),
      .overflow_irq(overflow_irq), .match_irq(match_irq),
      .waveform_out_bit(waveform_out_bit), .pin_out(pin_out),
      .pin_oe(pin_oe)
   );
   // ==========================================================
   // clock, reset and hang guard
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // whole run needs well under a thousand cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         finish_test();
      end
   end
   // ==========================================================
   // shared tasks
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q       = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
      chk({31'h0, e}, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q & m, exp);
   endtask
   // high byte first into the shared latch, low byte moves both
   task automatic w16(input logic [7:0] lo, input logic [15:0] v);
      wr(lo + 8'h04, {24'h0, v[15:8]});
      wr(lo, {24'h0, v[7:0]});
   endtask
   task automatic tick();
      @(posedge pclk);
      timer_tick <= 1'b1;
      @(posedge pclk);
      timer_tick <= 1'b0;
   endtask
   task automatic settle();
      @(negedge pclk);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      settle();
      chk({29'h0, waveform_out_bit}, 32'h0);
      chk({29'h0, pin_oe}, 32'h0);
      rd(ADDR_CONTROL, 32'hff, 32'h0);
      rd(ADDR_FLAGS, 32'hff, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_refuse();
      logic [31:0] q;
      logic        e;
      apb(1'b0, 8'h38, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      apb(1'b0, 8'h21, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      $display("test refuse done");
   endtask
   task automatic t_match_access();
      w16(ADDR_MATCH_A, 16'h1234);
      rd(ADDR_MATCH_A, 32'hff, 32'h34);
      rd(ADDR_MATCH_A + 8'h04, 32'hff, 32'h12);
      wr(ADDR_MATCH_A + 8'h04, 32'hab);
      rd(ADDR_MATCH_A + 8'h04, 32'hff, 32'h12);
      wr(ADDR_MATCH_A, 32'h34);
      rd(ADDR_MATCH_A + 8'h04, 32'hff, 32'hab);
      $display("test match access done");
   endtask
   task automatic t_block();
      wr(ADDR_CONTROL, 32'h00);
      w16(ADDR_MATCH_A, 16'h1234);
      w16(ADDR_CNT_LOW, 16'h1234);
      wr(ADDR_FLAGS, 32'h0f);
      wr(ADDR_CONTROL, 32'h20);
      tick();
      rd(ADDR_FLAGS, 32'h02, 32'h0);
      rd(ADDR_CNT_LOW, 32'hff, 32'h35);
      rd(ADDR_CNT_HIGH, 32'hff, 32'h12);
      wr(ADDR_CONTROL, 32'h00);
      w16(ADDR_CNT_LOW, 16'h1233);
      wr(ADDR_CONTROL, 32'h20);
      tick();
      rd(ADDR_FLAGS, 32'h02, 32'h0);
      tick();
      rd(ADDR_FLAGS, 32'h02, 32'h02);
      wr(ADDR_CONTROL, 32'h00);
      tick();
      rd(ADDR_CNT_LOW, 32'hff, 32'h35);
      $display("test block done");
   endtask
   task automatic t_irq();
      wr(ADDR_IRQ_EN, 32'h02);
      settle();
      chk({29'h0, match_irq}, 32'h1);
      @(posedge pclk);
      irq_ack <= 4'h2;
      @(posedge pclk);
      irq_ack <= 4'h0;
      settle();
      chk({29'h0, match_irq}, 32'h0);
      rd(ADDR_FLAGS, 32'h02, 32'h0);
      w16(ADDR_CNT_LOW, 16'hfffe);
      wr(ADDR_CONTROL, 32'h20);
      tick();
      tick();
      wr(ADDR_CONTROL, 32'h00);
      rd(ADDR_CNT_LOW, 32'hff, 32'h00);
      rd(ADDR_CNT_HIGH, 32'hff, 32'h00);
      rd(ADDR_FLAGS, 32'h01, 32'h01);
      wr(ADDR_IRQ_EN, 32'h01);
      settle();
      chk({31'h0, overflow_irq}, 32'h1);
      wr(ADDR_FLAGS, 32'h01);
      rd(ADDR_FLAGS, 32'h01, 32'h0);
      $display("test irq done");
   endtask
   task automatic t_force();
      logic [1:0] act [5] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_TOGGLE,
                              ACT_NONE};
      logic       exp [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      wr(ADDR_FLAGS, 32'h0f);
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_ACTION, {30'h0, act[i]});
         wr(ADDR_FORCE, 32'h01);
         settle();
         chk({31'h0, waveform_out_bit[0]}, {31'h0, exp[i]});
      end
      rd(ADDR_FLAGS, 32'h02, 32'h0);
      rd(ADDR_CNT_LOW, 32'hff, 32'h00);
      wr(ADDR_ACTION, {30'h0, ACT_SET});
      wr(ADDR_FORCE, 32'h01);
      settle();
      chk({29'h0, waveform_out_bit}, 32'h1);
      $display("test force done");
   endtask
   task automatic t_pins();
      wr(ADDR_PINS, 32'h27);
      settle();
      chk({29'h0, pin_oe}, 32'h7);
      chk({29'h0, pin_out}, 32'h5);
      wr(ADDR_PINS, 32'h21);
      settle();
      chk({29'h0, pin_oe}, 32'h1);
      $display("test pins done");
   endtask
   task automatic t_buffer();
      w16(ADDR_MATCH_A + 8'h08, 16'h0008);
      wr(ADDR_CONTROL, 32'h0e);
      settle();
      chk({29'h0, waveform_out_bit}, 32'h1);
      wr(ADDR_FORCE, 32'h01);
      wr(ADDR_ACTION, {30'h0, ACT_CLEAR});
      wr(ADDR_FORCE, 32'h01);
      settle();
      chk({29'h0, waveform_out_bit}, 32'h1);
      w16(ADDR_MATCH_A + 8'h08, 16'h0006);
      rd(ADDR_MATCH_A + 8'h08, 32'hff, 32'h06);
      w16(ADDR_CNT_LOW, 16'h0004);
      wr(ADDR_FLAGS, 32'h0f);
      wr(ADDR_CONTROL, 32'h2e);
      for (int i = 0; i < 3; i++) tick();
      rd(ADDR_FLAGS, 32'h04, 32'h0);
      tick();
      tick();
      rd(ADDR_FLAGS, 32'h04, 32'h04);
      wr(ADDR_CONTROL, 32'h00);
      $display("test buffer done");
   endtask
   task automatic t_run();
      logic [31:0] q;
      logic        e;
      wr(ADDR_CONTROL, 32'h10);
      w16(ADDR_CNT_LOW, 16'h0100);
      apb(1'b0, ADDR_CNT_LOW, 32'h0, q, e);
      chk({31'h0, q <= 32'h4}, 32'h1);
      wr(ADDR_CONTROL, 32'h00);
      $display("test run done");
   endtask
   // channel A as top: clear on match, toggle output
   task automatic t_ctc();
      wr(ADDR_FLAGS, 32'h0f);
      w16(ADDR_MATCH_A, 16'h0003);
      w16(ADDR_CNT_LOW, 16'h0002);
      wr(ADDR_ACTION, {30'h0, ACT_TOGGLE});
      wr(ADDR_CONTROL, 32'h24);
      tick();
      tick();
      wr(ADDR_CONTROL, 32'h00);
      rd(ADDR_CNT_LOW, 32'hff, 32'h00);
      rd(ADDR_CNT_HIGH, 32'hff, 32'h00);
      rd(ADDR_FLAGS, 32'h02, 32'h02);
      settle();
      chk({31'h0, waveform_out_bit[0]}, 32'h0);
      $display("test ctc done");
   endtask
   // ==========================================================
   // main sequence
   initial begin
      presetn       = 1'b0;
      psel          = 1'b0;
      penable       = 1'b0;
      pwrite        = 1'b0;
      paddr         = 8'h00;
      pwdata        = 32'h0;
      timer_tick    = 1'b0;
      capture_value = 16'h0020;
      irq_ack       = 4'h0;
      n_errors      = 0;
      num_checks    = 0;
      cycles        = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_refuse();
      t_match_access();
      t_block();
      t_irq();
      t_force();
      t_pins();
      t_buffer();
      t_run();
      t_ctc();
      finish_test();
   end
endmodule
`default_nettype wire
